/* core/wws_pkg.sv */
// constants, types and register map of the window watchdog supervisor
package wws_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned US_W    = 24;

  localparam logic [7:0] OFS_WIN_CAP  = 8'h00;
  localparam logic [7:0] OFS_HOLD_CAP = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;

  localparam logic [US_W-1:0] WIN_CAP_RST  = 24'h0003E8;
  localparam logic [US_W-1:0] HOLD_CAP_RST = 24'h0000C8;

  localparam int unsigned EV_EARLY = 0;
  localparam int unsigned EV_LATE  = 1;
  localparam int unsigned EV_DONE  = 2;
  localparam int unsigned EV_W     = 3;

  // ratio shifts: lower bound is upper bound shifted right
  localparam logic [1:0] SEL_OFF   = 2'h0;
  localparam logic [1:0] SEL_EIGHT = 2'h1;
  localparam logic [1:0] SEL_QUART = 2'h2;
  localparam logic [1:0] SEL_HALF  = 2'h3;
  localparam logic [1:0] SHIFT_EIGHT = 2'h3;
  localparam logic [1:0] SHIFT_QUART = 2'h2;
  localparam logic [1:0] SHIFT_HALF  = 2'h1;

  typedef enum logic [1:0] {
    PM_CAP    = 2'h0,
    PM_PULLUP = 2'h1,
    PM_OPEN   = 2'h2
  } wws_pin_mode_t;

  // gray along powerup -> monitor -> fault -> monitor; disabled off the side
  typedef enum logic [1:0] {
    ST_POWERUP  = 2'h0,
    ST_MONITOR  = 2'h1,
    ST_FAULT    = 2'h3,
    ST_DISABLED = 2'h2
  } wws_state_t;

  typedef struct packed {
    logic          kick;
    logic [1:0]    sel;
    wws_pin_mode_t tmode;
    wws_pin_mode_t dmode;
  } wws_pins_t;

  localparam int unsigned PINS_W = $bits(wws_pins_t);

endpackage : wws_pkg

/* core/wws_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module wws_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : wws_sync
`default_nettype wire

/* core/wws_top.sv */
// window watchdog supervisor with apb register slave
`timescale 1ns/10ps
`default_nettype none
module wws_top
  import wws_pkg::*;
#(
  parameter int unsigned CNT_W        = 32,
  parameter int unsigned UPPER_PU_US  = 1000,
  parameter int unsigned UPPER_NC_US  = 10000,
  parameter int unsigned HOLD_PU_US   = 200,
  parameter int unsigned HOLD_NC_US   = 1000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        kick_input,
  input  wire logic        window_select_0,
  input  wire logic        window_select_1,
  input  wire logic [1:0]  timeout_program_pin,
  input  wire logic [1:0]  delay_program_pin,
  output logic             fault_output_n_o,
  output logic             fault_output_n_oe,
  output logic             irq
);

  if (CNT_W < US_W + 8) begin : g_chk
    $error("CNT_W too narrow for microsecond to cycle conversion");
  end

  wws_pins_t        pins_raw;
  wws_pins_t        pins;
  wws_state_t       state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             kick_prev_q;
  logic             kick_fall;
  logic [US_W-1:0]  win_cap_q;
  logic [US_W-1:0]  hold_cap_q;
  logic [EV_W-1:0]  int_stat_q;
  logic [EV_W-1:0]  int_mask_q;
  logic [EV_W-1:0]  ev;
  logic [CNT_W-1:0] upper_cyc;
  logic [CNT_W-1:0] lower_cyc;
  logic [CNT_W-1:0] hold_cyc;
  logic [1:0]       shift;
  logic             disabled;
  logic             wr_en;
  logic             acc_q;

  localparam logic [CNT_W-1:0] UPPER_PU_CYC = CNT_W'(UPPER_PU_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] UPPER_NC_CYC = CNT_W'(UPPER_NC_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] HOLD_PU_CYC  = CNT_W'(HOLD_PU_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] HOLD_NC_CYC  = CNT_W'(HOLD_NC_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] MHZ_W        = CNT_W'(CLK_MHZ);

  always_comb begin
    pins_raw.kick  = kick_input;
    pins_raw.sel   = {window_select_1, window_select_0};
    pins_raw.tmode = wws_pin_mode_t'(timeout_program_pin);
    pins_raw.dmode = wws_pin_mode_t'(delay_program_pin);
  end

  wws_sync #(
    .WIDTH (PINS_W)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pins_raw),
    .q       (pins)
  );

  // timing decode from the configuration pins
  always_comb begin
    disabled = (pins.sel == SEL_OFF);
    case (pins.sel)
      SEL_EIGHT: shift = SHIFT_EIGHT;
      SEL_QUART: shift = SHIFT_QUART;
      default:   shift = SHIFT_HALF;
    endcase
    case (pins.tmode)
      PM_CAP:    upper_cyc = CNT_W'(win_cap_q) * MHZ_W;
      PM_PULLUP: upper_cyc = UPPER_PU_CYC;
      default:   upper_cyc = UPPER_NC_CYC;
    endcase
    lower_cyc = upper_cyc >> shift;
    case (pins.dmode)
      PM_CAP:    hold_cyc = CNT_W'(hold_cap_q) * MHZ_W;
      PM_PULLUP: hold_cyc = HOLD_PU_CYC;
      default:   hold_cyc = HOLD_NC_CYC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_prev_q <= 1'b0;
    end else begin
      kick_prev_q <= pins.kick;
    end
  end

  assign kick_fall = kick_prev_q & ~pins.kick;

  // supervision state machine and its single counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_POWERUP;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_POWERUP: begin
          // kicks are not looked at here
          if (cnt_q >= hold_cyc) begin
            state_q <= disabled ? ST_DISABLED : ST_MONITOR;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_MONITOR: begin
          if (disabled) begin
            state_q <= ST_DISABLED;
            cnt_q   <= '0;
          end else if (kick_fall && cnt_q < lower_cyc) begin
            state_q <= ST_FAULT;
            cnt_q   <= '0;
          end else if (kick_fall) begin
            cnt_q <= '0;
          end else if (cnt_q >= upper_cyc) begin
            state_q <= ST_FAULT;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_FAULT: begin
          // kick edges have no effect during the hold
          if (disabled) begin
            state_q <= ST_DISABLED;
            cnt_q   <= '0;
          end else if (cnt_q >= hold_cyc) begin
            state_q <= ST_MONITOR;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          cnt_q <= '0;
          if (!disabled) begin
            state_q <= ST_MONITOR;
          end
        end
      endcase
    end
  end

  // open-drain fault pin: only ever pulls low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_output_n_o  <= 1'b0;
      fault_output_n_oe <= 1'b0;
    end else begin
      fault_output_n_o  <= 1'b0;
      fault_output_n_oe <= (state_q == ST_MONITOR && !disabled &&
                            ((kick_fall && cnt_q < lower_cyc) ||
                             (!kick_fall && cnt_q >= upper_cyc))) ||
                           (state_q == ST_FAULT && !disabled &&
                            cnt_q < hold_cyc);
    end
  end

  always_comb begin
    ev           = '0;
    ev[EV_EARLY] = state_q == ST_MONITOR && !disabled && kick_fall && cnt_q < lower_cyc;
    ev[EV_LATE]  = state_q == ST_MONITOR && !disabled && !kick_fall && cnt_q >= upper_cyc;
    ev[EV_DONE]  = state_q == ST_FAULT && !disabled && cnt_q >= hold_cyc;
  end

  // apb: one wait cycle so read data comes from a flop
  assign wr_en = psel & penable & pwrite & acc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      acc_q   <= psel & penable & ~acc_q;
      pready  <= psel & penable & ~acc_q;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && penable && !acc_q) begin
        if (paddr == OFS_WIN_CAP) begin
          prdata <= 32'(win_cap_q);
        end else if (paddr == OFS_HOLD_CAP) begin
          prdata <= 32'(hold_cap_q);
        end else if (paddr == OFS_STATUS) begin
          prdata <= 32'({pins.dmode, pins.tmode, pins.sel, fault_output_n_oe, state_q});
        end else if (paddr == OFS_INT_STAT) begin
          prdata <= 32'(int_stat_q);
        end else if (paddr == OFS_INT_MASK) begin
          prdata <= 32'(int_mask_q);
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cap_q  <= WIN_CAP_RST;
      hold_cap_q <= HOLD_CAP_RST;
      int_mask_q <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_WIN_CAP) begin
        win_cap_q <= pwdata[US_W-1:0];
      end else if (paddr == OFS_HOLD_CAP) begin
        hold_cap_q <= pwdata[US_W-1:0];
      end else if (paddr == OFS_INT_MASK) begin
        int_mask_q <= pwdata[EV_W-1:0];
      end
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_en && paddr == OFS_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~pwdata[EV_W-1:0]) | ev;
      end else begin
        int_stat_q <= int_stat_q | ev;
      end
      irq <= |(int_stat_q & int_mask_q);
    end
  end

endmodule : wws_top
`default_nettype wire

/* sim/tb_top.sv */
// testbench for the window watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import wws_pkg::*;
  localparam int HOLD = 125;
  localparam int UP = 125;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic window_select_0 = 1'b1, window_select_1 = 1'b1;
  logic [1:0] timeout_program_pin = 2'h1, delay_program_pin = 2'h1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, kick_input, fault_output_n_o, fault_output_n_oe, irq;
  wire fault_pin = fault_output_n_oe ? 1'b0 : 1'b1;
  int error_cnt = 0, n_tests = 0, n;
  always #4 pclk = ~pclk;
  wws_top #(.UPPER_PU_US(1), .UPPER_NC_US(2), .HOLD_PU_US(1), .HOLD_NC_US(1)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .kick_input, .window_select_0, .window_select_1, .timeout_program_pin,
    .delay_program_pin, .fault_output_n_o, .fault_output_n_oe, .irq);
  wws_host u_host (.pclk, .presetn, .go, .kick_input);
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready read at the edge itself, so data and release belong to it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic wait_oe(input logic v, input int mx);
    n = 0;
    while (fault_output_n_oe !== v && n < mx) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wait_oe
  task automatic kick();
    @(posedge pclk);
    go <= ~go;
    #1;
  endtask : kick
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : cyc
  task automatic t_regs();
    apb(1'b0, OFS_WIN_CAP, 32'h0);
    chk(rd, 32'h000003E8);
    apb(1'b0, OFS_HOLD_CAP, 32'h0);
    chk(rd, 32'h000000C8);
    apb(1'b1, OFS_INT_MASK, 32'h00000003);
    apb(1'b0, OFS_INT_MASK, 32'h0);
    chk(rd, 32'h00000003);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h00000001);
  endtask : t_regs
  task automatic t_pwrup();
    kick();
    cyc(10);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h000000B8);
    chk({31'h0, fault_pin}, 32'h00000001);
    cyc(HOLD);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h000000B9);
  endtask : t_pwrup
  task automatic t_fault();
    kick();
    wait_oe(1'b1, 20);
    chk({31'h0, fault_pin}, 32'h0);
    kick();
    wait_oe(1'b0, 300);
    chk(32'(n), 32'(HOLD));
    wait_oe(1'b1, 300);
    chk(32'(n >= UP - 1 && n <= UP + 3), 32'h1);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(rd & 32'h3, 32'h00000003);
    chk({31'h0, irq}, 32'h00000001);
    apb(1'b1, OFS_INT_STAT, 32'h00000007);
    wait_oe(1'b0, 300);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(rd & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_fault
  task automatic t_good();
    repeat (3) begin
      cyc(80);
      kick();
    end
    cyc(20);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(rd & 32'h3, 32'h0);
    chk({31'h0, fault_pin}, 32'h00000001);
  endtask : t_good
  task automatic t_cap();
    apb(1'b1, OFS_WIN_CAP, 32'h00000002);
    apb(1'b1, OFS_HOLD_CAP, 32'h00000002);
    @(posedge pclk);
    window_select_1 <= 1'b0;
    timeout_program_pin <= 2'h0;
    delay_program_pin <= 2'h0;
    cyc(10);
    // early for the half ratio, legal for the eighth
    kick();
    cyc(200);
    // past the pull-up bound, inside the capacitor bound
    kick();
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(rd & 32'h3, 32'h0);
    wait_oe(1'b1, 400);
    chk(32'(n >= 2 * UP - 1 && n <= 2 * UP + 3), 32'h1);
    wait_oe(1'b0, 400);
    chk(32'(n), 32'(2 * HOLD + 1));
    @(posedge pclk);
    window_select_1 <= 1'b1;
    timeout_program_pin <= 2'h1;
    delay_program_pin <= 2'h1;
  endtask : t_cap
  task automatic t_dis();
    kick();
    wait_oe(1'b1, 20);
    chk({31'h0, fault_pin}, 32'h0);
    @(posedge pclk);
    window_select_0 <= 1'b0;
    window_select_1 <= 1'b0;
    timeout_program_pin <= 2'h2;
    wait_oe(1'b0, 20);
    chk(32'(n <= 4), 32'h1);
    apb(1'b1, OFS_INT_STAT, 32'h00000007);
    repeat (4) begin
      cyc(40);
      kick();
    end
    chk({31'h0, fault_pin}, 32'h00000001);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h000000C2);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(rd, 32'h0);
  endtask : t_dis
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_regs();
    t_pwrup();
    t_fault();
    t_good();
    t_cap();
    t_dis();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

/* sim/wws_host.sv */
// host model that strikes the kick input
`timescale 1ns/10ps
`default_nettype none
module wws_host (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic go,
  output logic      kick_input
);
  logic       go_q;
  logic [2:0] low_q;
  // each toggle of go gives one fall, low long enough for the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q  <= 1'b0;
      low_q <= 3'h0;
    end else begin
      go_q <= go;
      if (go != go_q) low_q <= 3'h4;
      else if (low_q != 3'h0) low_q <= low_q - 3'h1;
    end
  end
  // always a firm level, never floating
  assign kick_input = (low_q == 3'h0);
endmodule : wws_host
`default_nettype wire

/* sim/wws_props.sv */
// port assertions for the watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
module wws_props #(
  parameter int unsigned HOLD_PU_US = 200
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        window_select_0,
  input wire logic        window_select_1,
  input wire logic        fault_output_n_oe
);
  localparam int unsigned PU_MIN = HOLD_PU_US * 125 - 20;
  int unsigned up_q;
  // saturates, so a long run cannot wrap into the power-up span
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 0;
    else if (up_q < 4096) up_q <= up_q + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_off;
    !window_select_0 && !window_select_1;
  endsequence
  sequence s_rise;
    $rose(fault_output_n_oe);
  endsequence
  AST_PWRUP: assert property (up_q < PU_MIN |-> !fault_output_n_oe)
    else $error("fault output during power-up");
  AST_DIS_REL: assert property (s_off [*6] |-> !fault_output_n_oe)
    else $error("fault output while disabled");
  AST_HOLD: assert property (s_rise |-> (fault_output_n_oe || !window_select_0 && !window_select_1) [*8])
    else $error("fault output released early");
  AST_PRDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PRDY_ANS: assert property (psel && penable && !pready |=> pready)
    else $error("no answer in access cycle two");
  AST_PRDY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  AST_PRDATA: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
endmodule : wws_props
bind wws_top wws_props #(.HOLD_PU_US(HOLD_PU_US)) u_props (.pclk, .presetn, .psel, .penable,
  .prdata, .pready, .pslverr, .window_select_0, .window_select_1, .fault_output_n_oe);
`default_nettype wire
